// ---- verilog/mw3_pkg.sv ----
package mw3_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int SYS_CLK_MHZ   = 250;
  // longest program time, rounded down to whole cycles
  localparam int PROG_TIME_MS  = 10;
  localparam int PROG_CYC      = PROG_TIME_MS * 1000 * SYS_CLK_MHZ;
  // fastest serial clock 1.25 MHz, so each half is 400 ns
  localparam int SCK_PERIOD_NS = 800;
  localparam int SCK_HALF_CYC  = (SCK_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CS_LOW_NS     = 200;
  localparam int CS_LOW_CYC    = (CS_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] SCK_HALF_LD = 8'(SCK_HALF_CYC - 1);
  localparam logic [7:0] CS_LOW_LD   = 8'(CS_LOW_CYC - 1);

  // ---------------------------------------------------------------
  // array geometry and frame fields
  // ---------------------------------------------------------------
  localparam int ADDR_W = 10;
  localparam int DATA_W = 16;
  localparam int WORDS  = 1024;
  localparam int BLK_W  = 3;
  localparam logic [21:0] FILL_SPAN = 22'h000080;
  localparam logic [21:0] TMR_LAST  = 22'h000001;
  localparam logic [4:0]  OPC_BITS_M1  = 5'h01;
  localparam logic [4:0]  ADDR_BITS_M1 = 5'h09;
  localparam logic [4:0]  DATA_BITS_M1 = 5'h0f;
  localparam logic [4:0]  FRAME_SHORT  = 5'h0d;
  localparam logic [4:0]  FRAME_LONG   = 5'h1d;
  localparam logic [1:0]  OPC_READ     = 2'h2;
  localparam logic [1:0]  OPC_WRITE    = 2'h1;
  localparam logic [1:0]  OPC_SPECIAL  = 2'h0;
  localparam logic [1:0]  SUB_ENABLE   = 2'h3;
  localparam logic [1:0]  SUB_LOCK     = 2'h0;
  localparam logic [1:0]  SUB_FILL     = 2'h1;

  // host user commands
  localparam logic [2:0] HOP_READ   = 3'h0;
  localparam logic [2:0] HOP_WRITE  = 3'h1;
  localparam logic [2:0] HOP_FILL   = 3'h2;
  localparam logic [2:0] HOP_ENABLE = 3'h3;
  localparam logic [2:0] HOP_LOCK   = 3'h4;

  // ---------------------------------------------------------------
  // device state
  // ---------------------------------------------------------------
  typedef enum logic [6:0] {
    D_IDLE  = 7'h01,
    D_OPC   = 7'h02,
    D_ADDR  = 7'h04,
    D_DATA  = 7'h08,
    D_READ  = 7'h10,
    D_ARMED = 7'h20,
    D_DEAD  = 7'h40
  } mw3_dstate_t;

  typedef struct packed {
    mw3_dstate_t        st;
    logic               cs_m, cs_s, ck_m, ck_s, ck_p, sd_m, sd_s;
    logic [4:0]         cnt;
    logic [1:0]         opc;
    logic [ADDR_W-1:0]  addr;
    logic [DATA_W-1:0]  sh;
    logic [3:0]         rcnt;
    logic               dout, wel, busy, show;
    logic [21:0]        tmr;
  } mw3_dev_t;

  localparam mw3_dev_t DEV_RST = '{st: D_IDLE, default: '0};

  // ---------------------------------------------------------------
  // host state
  // ---------------------------------------------------------------
  typedef enum logic [6:0] {
    H_IDLE = 7'h01,
    H_GAP  = 7'h02,
    H_LOW  = 7'h04,
    H_HIGH = 7'h08,
    H_CSDN = 7'h10,
    H_STLO = 7'h20,
    H_POLL = 7'h40
  } mw3_hstate_t;

  typedef struct packed {
    mw3_hstate_t        st;
    logic               cs, ck, sd, do_m, do_s, rd, prog, done;
    logic [7:0]         tmr;
    logic [28:0]        sh;
    logic [4:0]         nb;
    logic [7:0]         words;
    logic [DATA_W-1:0]  rsh;
    logic [4:0]         rb;
    logic [DATA_W-1:0]  f0, f1;
    logic [1:0]         fcnt;
  } mw3_host_t;

  localparam mw3_host_t HOST_RST = '{st: H_IDLE, default: '0};

endpackage

// ---- verilog/mw3_if.sv ----
`timescale 1ns/100ps
interface mw3_if;
  logic chip_sel;
  logic serial_clock_in;
  logic serial_in_line;
  logic data_out_val;
  logic data_out_oe;
  logic data_out_line;

  // no pull resistor modelled: an undriven line reads low
  assign data_out_line = data_out_oe & data_out_val;

  modport dev  (input chip_sel, serial_clock_in, serial_in_line,
                output data_out_val, data_out_oe);
  modport host (output chip_sel, serial_clock_in, serial_in_line,
                input data_out_line);
endinterface

// ---- verilog/mw3_dev.sv ----
`timescale 1ns/100ps
// Operation
// - sample serial input at each clock rise
// - read bits change at serial clock rise
// - status after write, float while deselected
// - host deselects between commands
// - first sampled one is the start bit
// - opcode, address, data, msb first
// - opcode selects read, write or special
// - special kind from top two address bits
// - address field is ten bits wide
// - dummy zero at last address bit
// - read streams words with address increment
// - deselect right after last data bit programs
// - extra clock before deselect cancels write
// - timed program cycle, busy rejects commands
// - block fill writes 128 equal words
// - block number picks 128-word range
// - latch clear at reset, reads allowed whatever the latch
// - enable sets latch, lock clears it
// - host clocks all address bits for specials
// - host offers lock command after writes
// - started program cycle cannot be cancelled
// - host moves select only while clock low
module mw3_dev
  import mw3_pkg::*;
#(
  parameter int PROG_CYC_P = PROG_CYC
) (
  input  wire logic SYS_CLK_IN,
  input  wire logic RSTN_IN,
  mw3_if.dev        LINK,
  output logic      BUSY_OUT,
  output logic      WRITE_EN_OUT
);

  // ---------------------------------------------------------------
  // storage and helpers
  // ---------------------------------------------------------------
  mw3_dev_t          q;
  mw3_dev_t          d;
  logic [DATA_W-1:0] mem [WORDS];
  logic [DATA_W-1:0] mem_rd;
  logic [DATA_W-1:0] word;
  logic [ADDR_W-1:0] a_nx;
  logic [ADDR_W-1:0] mem_wa;
  logic              fill;
  logic              mem_we;
  logic              rise;

  // the array is never reset: its content must survive a reset
  always_ff @(posedge SYS_CLK_IN) begin
    if (mem_we) begin
      mem[mem_wa] <= q.sh;
    end
  end

  // ---------------------------------------------------------------
  // program cycle addressing
  // ---------------------------------------------------------------
  // opcode 00 only reaches a program cycle as a block fill
  assign fill   = (q.opc == OPC_SPECIAL);
  assign mem_rd = mem[q.addr];
  // serial clock edge seen through the synchroniser
  assign rise   = q.ck_s & ~q.ck_p;
  // address shift with the bit being sampled now
  assign a_nx   = {q.addr[ADDR_W-2:0], q.sd_s};
  // a fill writes one word per cycle in the last 128 timer counts,
  // a single write lands in the very last count
  assign mem_we = q.busy &
                  (fill ? (q.tmr <= FILL_SPAN)
                        : (q.tmr == TMR_LAST));
  // block number in the low address bits picks the 128-word range
  assign mem_wa = fill ? {q.addr[BLK_W-1:0], 7'(q.tmr - TMR_LAST)}
                       : q.addr;

  // ---------------------------------------------------------------
  // command engine
  // ---------------------------------------------------------------
  always_comb begin
    d    = q;
    word = (q.rcnt == 4'h0) ? mem_rd : q.sh;

    // two flip-flops for every pin plus a third on the clock for edge detection, the first is read by nobody else
    d.cs_m = LINK.chip_sel;
    d.cs_s = q.cs_m;
    d.ck_m = LINK.serial_clock_in;
    d.ck_s = q.ck_m;
    d.ck_p = q.ck_s;
    d.sd_m = LINK.serial_in_line;
    d.sd_s = q.sd_m;

    // self-timed cycle runs free of select and clock once started
    if (q.busy) begin
      d.tmr = q.tmr - TMR_LAST;
      if (q.tmr == TMR_LAST) begin
        d.busy = 1'b0;
      end
    end

    if (!q.cs_s) begin
      // deselect resets the engine; armed means last data bit was
      // the latest clock, so this is the window that programs
      if (q.st == D_ARMED) begin
        d.busy = 1'b1;
        d.tmr  = 22'(PROG_CYC_P);
        d.show = 1'b1;
      end
      d.st = D_IDLE;
    end else if (rise) begin
      unique case (q.st)
        D_IDLE: begin
          // zeros before the start bit fall through; busy rejects
          if (q.sd_s && !q.busy) begin
            d.st   = D_OPC;
            d.cnt  = OPC_BITS_M1;
            d.show = 1'b0;
          end
        end
        D_OPC: begin
          d.opc = {q.opc[0], q.sd_s};
          if (q.cnt == 5'h00) begin
            d.st  = D_ADDR;
            d.cnt = ADDR_BITS_M1;
          end else begin
            d.cnt = q.cnt - 5'h01;
          end
        end
        D_ADDR: begin
          d.addr = a_nx;
          d.cnt  = q.cnt - 5'h01;
          if (q.cnt == 5'h00) begin
            d.cnt = DATA_BITS_M1;
            d.st  = D_DEAD;
            if (q.opc == OPC_READ) begin
              d.st   = D_READ;
              d.dout = 1'b0;
              d.rcnt = 4'h0;
            end else if (q.opc == OPC_WRITE) begin
              // a cleared latch ignores the rest of the frame
              if (q.wel) begin
                d.st = D_DATA;
              end
            end else if (q.opc == OPC_SPECIAL) begin
              // only the top two bits pick the kind; a fill uses the low bits as block number
              if (a_nx[ADDR_W-1 -: 2] == SUB_ENABLE) begin
                d.wel = 1'b1;
              end else if (a_nx[ADDR_W-1 -: 2] == SUB_LOCK) begin
                d.wel = 1'b0;
              end else if (a_nx[ADDR_W-1 -: 2] == SUB_FILL) begin
                if (q.wel) begin
                  d.st = D_DATA;
                end
              end
            end
          end
        end
        D_DATA: begin
          d.sh  = {q.sh[DATA_W-2:0], q.sd_s};
          d.cnt = q.cnt - 5'h01;
          if (q.cnt == 5'h00) begin
            d.st = D_ARMED;
          end
        end
        D_READ: begin
          // each rise presents the next bit, msb first
          d.dout = word[DATA_W-1];
          d.sh   = {word[DATA_W-2:0], 1'b0};
          d.rcnt = q.rcnt + 4'h1;
          // after the last bit the next rise starts the next word
          if (q.rcnt == 4'hf) begin
            d.addr = q.addr + 10'h001;
          end
        end
        D_ARMED: begin
          // a further clock before deselect throws the frame away
          d.st = D_DEAD;
        end
        D_DEAD: begin
          // wait for deselect
          d.st = D_DEAD;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  // reset stands for power-up, so it also clears the write latch
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RSTN_IN) begin
      q <= DEV_RST;
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // the line floats whenever the part is deselected; status shows
  // only in idle after a program start, until the next start bit
  assign LINK.data_out_oe  = q.cs_s &
                             ((q.st == D_READ) |
                              ((q.st == D_IDLE) & q.show));
  // status reads low while busy, high when ready
  assign LINK.data_out_val = (q.st == D_READ) ? q.dout : ~q.busy;
  assign BUSY_OUT          = q.busy;
  assign WRITE_EN_OUT      = q.wel;

endmodule // mw3_dev

// ---- verilog/mw3_host.sv ----
`timescale 1ns/100ps
module mw3_host
  import mw3_pkg::*;
(
  input  wire logic        SYS_CLK_IN,
  input  wire logic        RSTN_IN,
  input  wire logic        CMD_VALID_IN,
  output logic             CMD_READY_OUT,
  input  wire logic [2:0]  CMD_OP_IN,
  input  wire logic [9:0]  CMD_ADDR_IN,
  input  wire logic [15:0] CMD_DATA_IN,
  input  wire logic [7:0]  CMD_WORDS_IN,
  output logic             RD_VALID_OUT,
  input  wire logic        RD_READY_IN,
  output logic [15:0]      RD_DATA_OUT,
  output logic             DONE_OUT,
  mw3_if.host              LINK
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  mw3_host_t         q;
  mw3_host_t         d;
  logic              tmr_z;
  logic              pop;
  logic              prog_op;
  logic [1:0]        opc;
  logic [ADDR_W-1:0] fa;
  logic [DATA_W-1:0] fd;

  assign tmr_z   = (q.tmr == 8'h00);
  assign pop     = (q.fcnt != 2'h0) & RD_READY_IN;
  assign prog_op = (CMD_OP_IN == HOP_WRITE) | (CMD_OP_IN == HOP_FILL);

  // frame fields for the command offered at the user port
  always_comb begin
    opc = OPC_SPECIAL;
    fa  = CMD_ADDR_IN;
    fd  = 16'h0000;
    unique case (CMD_OP_IN)
      HOP_READ:   opc = OPC_READ;
      HOP_WRITE: begin
        opc = OPC_WRITE;
        fd  = CMD_DATA_IN;
      end
      HOP_FILL: begin
        fa = {SUB_FILL, 5'h00, CMD_ADDR_IN[BLK_W-1:0]};
        fd = CMD_DATA_IN;
      end
      HOP_ENABLE: fa = {SUB_ENABLE, 8'h00};
      // lock is offered so software can close writes when done
      HOP_LOCK:   fa = {SUB_LOCK, 8'h00};
      default:    fa = {SUB_LOCK, 8'h00};
    endcase
  end

  // ---------------------------------------------------------------
  // link sequencer and two-entry read buffer
  // ---------------------------------------------------------------
  always_comb begin
    d      = q;
    d.do_m = LINK.data_out_line;
    d.do_s = q.do_m;
    d.done = 1'b0;
    if (!tmr_z) begin
      d.tmr = q.tmr - 8'h01;
    end
    if (pop) begin
      d.f0   = q.f1;
      d.fcnt = q.fcnt - 2'h1;
    end
    unique case (q.st)
      H_IDLE: begin
        if (CMD_VALID_IN) begin
          // special frames still carry every address clock
          d.sh    = {1'b1, opc, fa, fd};
          d.nb    = prog_op ? FRAME_LONG : FRAME_SHORT;
          d.rd    = (CMD_OP_IN == HOP_READ);
          d.prog  = prog_op;
          d.words = CMD_WORDS_IN;
          d.rb    = 5'h00;
          d.tmr   = CS_LOW_LD;
          d.st    = H_GAP;
        end
      end
      H_GAP: begin
        if (tmr_z) begin
          d.cs  = 1'b1;
          d.sd  = q.sh[28];
          d.tmr = SCK_HALF_LD;
          d.st  = H_LOW;
        end
      end
      H_LOW: begin
        // a full buffer holds the clock low so no word is lost
        if (tmr_z && !(q.nb == 5'h00 && q.fcnt == 2'h2)) begin
          d.ck  = 1'b1;
          d.tmr = SCK_HALF_LD;
          d.st  = H_HIGH;
        end
      end
      H_HIGH: begin
        if (tmr_z) begin
          d.ck  = 1'b0;
          d.tmr = SCK_HALF_LD;
          d.st  = H_LOW;
          if (q.nb != 5'h00) begin
            d.nb = q.nb - 5'h01;
            d.sh = {q.sh[27:0], 1'b0};
            d.sd = q.sh[27];
            if (q.nb == 5'h01 && !q.rd) begin
              d.st = H_CSDN;
            end
          end else begin
            // sampled late in the high half, well after the change
            d.rsh = {q.rsh[DATA_W-2:0], q.do_s};
            d.rb  = q.rb + 5'h01;
            if (q.rb == 5'h0f) begin
              d.rb = 5'h00;
              if (d.fcnt == 2'h0) begin
                d.f0 = {q.rsh[DATA_W-2:0], q.do_s};
              end else begin
                d.f1 = {q.rsh[DATA_W-2:0], q.do_s};
              end
              d.fcnt  = d.fcnt + 2'h1;
              d.words = q.words - 8'h01;
              if (q.words == 8'h01) begin
                d.st = H_CSDN;
              end
            end
          end
        end
      end
      H_CSDN: begin
        // select drops a cycle after the clock fell, inside the window
        d.cs   = 1'b0;
        d.sd   = 1'b0;
        d.tmr  = CS_LOW_LD;
        d.done = !q.prog;
        d.st   = q.prog ? H_STLO : H_IDLE;
      end
      H_STLO: begin
        if (tmr_z) begin
          d.cs = 1'b1;
          d.st = H_POLL;
        end
      end
      H_POLL: begin
        // no clocks are given while status shows, so no start bit
        if (q.do_s) begin
          d.cs   = 1'b0;
          d.done = 1'b1;
          d.st   = H_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (!RSTN_IN) begin
      q <= HOST_RST;
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign CMD_READY_OUT        = (q.st == H_IDLE);
  assign RD_VALID_OUT         = (q.fcnt != 2'h0);
  assign RD_DATA_OUT          = q.f0;
  assign DONE_OUT             = q.done;
  assign LINK.chip_sel        = q.cs;
  assign LINK.serial_clock_in = q.ck;
  assign LINK.serial_in_line  = q.sd;

endmodule // mw3_host

// ---- verification/mw3_props.sv ----
`timescale 1ns/100ps
module mw3_props
  import mw3_pkg::*;
#(
  parameter int PROG_CYC_P = 300
) (
  input wire logic SYS_CLK_IN,
  input wire logic RSTN_IN,
  input wire logic chip_sel,
  input wire logic serial_clock_in,
  input wire logic serial_in_line,
  input wire logic data_out_val,
  input wire logic data_out_oe,
  input wire logic BUSY_OUT,
  input wire logic WRITE_EN_OUT
);
  // ---------------------------------------------------------------
  // frame tracker rebuilt from the pins
  // ---------------------------------------------------------------
  logic        ck_q, go_q, arm_q, rise, go, clk13;
  logic [4:0]  n_q;
  logic [3:0]  hdr_q;
  logic [7:0]  rise_age_q, fire_age_q;
  logic [21:0] busy_age_q;

  assign rise  = serial_clock_in & ~ck_q;
  assign go    = go_q | serial_in_line;
  assign clk13 = rise & go_q & (n_q == 5'h0c);

  // rise and fire ages saturate so a long idle stretch never wraps into a false match
  always_ff @(posedge SYS_CLK_IN) begin
    if (!RSTN_IN) begin
      ck_q       <= 1'b0;
      go_q       <= 1'b0;
      arm_q      <= 1'b0;
      n_q        <= 5'h00;
      hdr_q      <= 4'h0;
      rise_age_q <= 8'hff;
      fire_age_q <= 8'hff;
      busy_age_q <= 22'h000000;
    end else begin
      ck_q       <= serial_clock_in;
      rise_age_q <= rise ? 8'h00 : rise_age_q + {7'h00, rise_age_q != 8'hff};
      fire_age_q <= (arm_q & ~chip_sel) ? 8'h00 : fire_age_q + {7'h00, fire_age_q != 8'hff};
      busy_age_q <= BUSY_OUT ? busy_age_q + 22'h000001 : 22'h000000;
      if (!chip_sel) begin
        go_q  <= 1'b0;
        n_q   <= 5'h00;
        arm_q <= 1'b0;
      end else if (rise) begin
        go_q  <= go;
        n_q   <= (go && n_q != 5'h1f) ? n_q + 5'h01 : n_q;
        hdr_q <= (go_q && n_q < 5'h05) ? {hdr_q[2:0], serial_in_line} : hdr_q;
        arm_q <= go_q && n_q == 5'h1c && WRITE_EN_OUT &&
                 (hdr_q[3:2] == OPC_WRITE || hdr_q == {OPC_SPECIAL, SUB_FILL});
      end
    end
  end

  default clocking @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RSTN_IN);

  sequence s_read_tail;
    clk13 && hdr_q[3:2] == OPC_READ;
  endsequence
  sequence s_fire;
    arm_q && $fell(chip_sel);
  endsequence

  a_float_deselect: assert property ($fell(chip_sel) |-> ##[1:4] !data_out_oe)
    else $error("output still driven after deselect");
  a_quiet_idle: assert property ((!chip_sel)[*5] |-> !data_out_oe)
    else $error("output driven while deselected");
  a_bit_at_rise: assert property (data_out_oe && $past(data_out_oe) &&
      $changed(data_out_val) && rise_age_q < 8'hfa |-> rise_age_q <= 8'h05)
    else $error("read bit changed away from a clock rise");
  a_dummy_zero: assert property (s_read_tail |-> ##4 (data_out_oe && !data_out_val))
    else $error("no dummy zero at last address bit");
  a_enable_sets: assert property (clk13 && hdr_q == {OPC_SPECIAL, SUB_ENABLE} |-> ##4 WRITE_EN_OUT)
    else $error("enable command left latch clear");
  a_lock_clears: assert property (clk13 && hdr_q == {OPC_SPECIAL, SUB_LOCK} |-> ##4 !WRITE_EN_OUT)
    else $error("lock command left latch set");
  a_program_start: assert property (s_fire |-> ##[1:5] BUSY_OUT)
    else $error("timely deselect did not start programming");
  a_program_origin: assert property ($rose(BUSY_OUT) |-> fire_age_q <= 8'h06)
    else $error("programming started without a valid write frame");
  a_busy_length: assert property ($fell(BUSY_OUT) |->
      busy_age_q >= PROG_CYC_P - 2 && busy_age_q <= PROG_CYC_P + 2)
    else $error("program cycle length wrong");
  a_status_level: assert property (data_out_oe && chip_sel && !go_q && $stable(BUSY_OUT)
      |-> data_out_val == !BUSY_OUT)
    else $error("status level disagrees with busy");
endmodule // mw3_props

// ---- verification/mw3_bench.sv ----
`timescale 1ns/100ps
module mw3_bench
  import mw3_pkg::*;
;
  // ---------------------------------------------------------------
  // two devices, one host; the second link is bit-banged
  // ---------------------------------------------------------------
  localparam int sim_prog = 300;
  logic        sys_clk, rstn, cmd_valid, cmd_ready, rd_valid, rd_ready;
  logic        done, busy, wen, busy_b, wen_b;
  logic [2:0]  cmd_op;
  logic [9:0]  cmd_addr;
  logic [15:0] cmd_data, rd_data;
  logic [7:0]  cmd_words;
  logic [15:0] mem [0:1023];
  int          fail_count, compares, done_cnt, want_done, cycles;

  mw3_if u_mw3_if ();
  mw3_if u_mw3_if_b ();
  mw3_dev #(.PROG_CYC_P(sim_prog)) u_mw3_dev (.SYS_CLK_IN(sys_clk), .RSTN_IN(rstn),
    .LINK(u_mw3_if.dev), .BUSY_OUT(busy), .WRITE_EN_OUT(wen));
  mw3_dev #(.PROG_CYC_P(sim_prog)) u_mw3_dev_b (.SYS_CLK_IN(sys_clk), .RSTN_IN(rstn),
    .LINK(u_mw3_if_b.dev), .BUSY_OUT(busy_b), .WRITE_EN_OUT(wen_b));
  mw3_host u_mw3_host (.SYS_CLK_IN(sys_clk), .RSTN_IN(rstn), .CMD_VALID_IN(cmd_valid),
    .CMD_READY_OUT(cmd_ready), .CMD_OP_IN(cmd_op), .CMD_ADDR_IN(cmd_addr),
    .CMD_DATA_IN(cmd_data), .CMD_WORDS_IN(cmd_words), .RD_VALID_OUT(rd_valid),
    .RD_READY_IN(rd_ready), .RD_DATA_OUT(rd_data), .DONE_OUT(done), .LINK(u_mw3_if.host));
  mw3_props #(.PROG_CYC_P(sim_prog)) u_mw3_props (.SYS_CLK_IN(sys_clk), .RSTN_IN(rstn),
    .chip_sel(u_mw3_if.chip_sel), .serial_clock_in(u_mw3_if.serial_clock_in),
    .serial_in_line(u_mw3_if.serial_in_line), .data_out_val(u_mw3_if.data_out_val),
    .data_out_oe(u_mw3_if.data_out_oe), .BUSY_OUT(busy), .WRITE_EN_OUT(wen));

  initial sys_clk = 1'b0;
  always #2 sys_clk = ~sys_clk;

  // done strobes are counted so none is missed while words are popped
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (done === 1'b1)
      done_cnt <= done_cnt + 1;
    if (cycles == 100000) begin
      fail_count++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check_val(input logic [15:0] seen, input logic [15:0] expd);
    compares++;
    if (seen !== expd) begin
      fail_count++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, expd);
    end
  endtask

  // request held until the edge that samples ready; reads return early
  task automatic issue(input logic [2:0] op, input logic [9:0] addr,
                       input logic [15:0] data, input logic [7:0] words);
    @(negedge sys_clk);
    while (cmd_ready !== 1'b1) @(negedge sys_clk);
    want_done = done_cnt + 1;
    cmd_valid = 1'b1;
    cmd_op    = op;
    cmd_addr  = addr;
    cmd_data  = data;
    cmd_words = words;
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    while (done_cnt < want_done && op != HOP_READ) @(negedge sys_clk);
  endtask

  task automatic fill(input logic [2:0] blk, input logic [15:0] data);
    int i;
    issue(HOP_FILL, {7'h00, blk}, data, 8'h00);
    for (i = 0; i < 128; i++)
      mem[{blk, 7'(i)}] = data;
  endtask

  // first pop may stall long enough for the buffer to fill and refuse
  task automatic read_words(input logic [9:0] addr, input int n, input int stall);
    int i;
    issue(HOP_READ, addr, 16'h0000, 8'(n));
    for (i = 0; i < n; i++) begin
      while (rd_valid !== 1'b1) @(negedge sys_clk);
      repeat (i == 0 ? stall : 1) @(negedge sys_clk);
      check_val(rd_data, mem[10'(addr + 10'(i))]);
      rd_ready = 1'b1;
      @(negedge sys_clk);
      rd_ready = 1'b0;
      @(negedge sys_clk);
    end
    while (done_cnt < want_done) @(negedge sys_clk);
  endtask

  // bit-banged frame at a 64 ns clock, msb first; select moves with clock low
  task automatic raw_frame(input logic [31:0] bits, input int nbits);
    int i;
    @(negedge sys_clk);
    u_mw3_if_b.chip_sel = 1'b1;
    for (i = nbits - 1; i >= 0; i--) begin
      u_mw3_if_b.serial_in_line = bits[i];
      repeat (8) @(negedge sys_clk);
      u_mw3_if_b.serial_clock_in = 1'b1;
      repeat (8) @(negedge sys_clk);
      u_mw3_if_b.serial_clock_in = 1'b0;
    end
    repeat (4) @(negedge sys_clk);
    u_mw3_if_b.chip_sel = 1'b0;
    repeat (60) @(negedge sys_clk);
  endtask

  initial begin
    rstn = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = 3'h0;
    cmd_addr = 10'h000;
    cmd_data = 16'h0000;
    cmd_words = 8'h00;
    rd_ready = 1'b0;
    u_mw3_if_b.chip_sel = 1'b0;
    u_mw3_if_b.serial_clock_in = 1'b0;
    u_mw3_if_b.serial_in_line = 1'b0;
    repeat (2) @(negedge sys_clk);
    rstn = 1'b1;
    @(negedge sys_clk);
    check_val(16'(wen), 16'h0000);
    check_val(16'(u_mw3_if.data_out_oe), 16'h0000);
    // far-end misuse and wire checks
    raw_frame(32'({1'b1, OPC_WRITE, 10'h155, 16'h3c3c}), 29);
    check_val(16'(busy_b), 16'h0000);
    raw_frame(32'({3'b000, 1'b1, OPC_SPECIAL, SUB_ENABLE, 8'ha5}), 16);
    check_val(16'(wen_b), 16'h0001);
    raw_frame(32'({1'b1, OPC_WRITE, 10'h155, 16'h3c3c, 1'b0}), 30);
    check_val(16'(busy_b), 16'h0000);
    raw_frame(32'({1'b1, OPC_WRITE, 10'h155, 16'h3c3c}), 29);
    check_val(16'(busy_b), 16'h0001);
    u_mw3_if_b.chip_sel = 1'b1;
    repeat (10) @(negedge sys_clk);
    check_val(16'({u_mw3_if_b.data_out_oe, u_mw3_if_b.data_out_line}), 16'h0002);
    // a start bit while busy must be dropped, or the status would vanish
    u_mw3_if_b.serial_in_line = 1'b1;
    @(negedge sys_clk);
    u_mw3_if_b.serial_clock_in = 1'b1;
    repeat (8) @(negedge sys_clk);
    u_mw3_if_b.serial_clock_in = 1'b0;
    u_mw3_if_b.serial_in_line = 1'b0;
    repeat (sim_prog) @(negedge sys_clk);
    check_val(16'({u_mw3_if_b.data_out_oe, u_mw3_if_b.data_out_line}), 16'h0003);
    u_mw3_if_b.chip_sel = 1'b0;
    repeat (10) @(negedge sys_clk);
    check_val(16'(u_mw3_if_b.data_out_oe), 16'h0000);
    repeat (50) @(negedge sys_clk);
    // undefined opcode and special kind program nothing and keep the latch
    raw_frame(32'({1'b1, 2'h3, 10'h2aa, 16'h5555}), 29);
    check_val(16'(busy_b), 16'h0000);
    raw_frame(32'({1'b1, OPC_SPECIAL, 2'h2, 8'h00, 16'h5555}), 29);
    check_val(16'({busy_b, wen_b}), 16'h0001);
    raw_frame(32'({1'b1, OPC_SPECIAL, SUB_LOCK, 8'h5a}), 13);
    check_val(16'(wen_b), 16'h0000);
    // host-driven traffic
    issue(HOP_ENABLE, 10'h000, 16'h0000, 8'h00);
    check_val(16'(wen), 16'h0001);
    fill(3'h0, 16'h0f0f);
    fill(3'h1, 16'h9696);
    fill(3'h7, 16'hf0f0);
    issue(HOP_WRITE, 10'h07f, 16'h1234, 8'h00);
    mem[10'h07f] = 16'h1234;
    read_words(10'h3fe, 3, 6000);
    read_words(10'h07e, 3, 0);
    issue(HOP_LOCK, 10'h000, 16'h0000, 8'h00);
    check_val(16'(wen), 16'h0000);
    read_words(10'h000, 1, 0);
    complete_run();
  end
endmodule // mw3_bench
